// ==== rtl/acr_regs.svh ====
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ACR_ADDR_PORT_CFG 8'h00
`define ACR_ADDR_CHIP_IDENTIFIER 8'h01
`define ACR_ADDR_GRADE 8'h02
`define ACR_ADDR_MODES 8'h08
`define ACR_ADDR_CLOCK 8'h09
`define ACR_ADDR_COMMIT 8'hFF

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACR_RST_PORT_CFG 8'h18
`define ACR_RST_MODES 8'h00
`define ACR_RST_CLOCK 8'h01
`define ACR_RST_COMMIT 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define ACR_BIT_LSB_HI 6
`define ACR_BIT_RST_HI 5
`define ACR_BIT_RST_LO 2
`define ACR_BIT_LSB_LO 1
`define ACR_BIT_COMMIT 0
`define ACR_BIT_PIN_EN 7
`define ACR_BIT_DCS 0
`define ACR_BIT_FUNC_HI 6
`define ACR_BIT_FUNC_LO 5
`define ACR_BIT_MODE_HI 1
`define ACR_BIT_MODE_LO 0

// ----------------------------------------
// masks of implemented bits
// ----------------------------------------
`define ACR_MASK_PORT_CFG 8'h66
`define ACR_MASK_MODES 8'hE3
`define ACR_MASK_CLOCK 8'h01
`define ACR_MASK_GRADE 8'h70

`endif

// ==== rtl/acr_pkg.sv ====
package acr_pkg;

    typedef enum logic [1:0]
    {
        ACR_MODE_RUN = 2'b00,
        ACR_MODE_PDOWN = 2'b01,
        ACR_MODE_STANDBY = 2'b10,
        ACR_MODE_DRESET = 2'b11
    } acr_mode_t;

    // register write/read request
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acr_req_t;

    // active device settings
    typedef struct packed
    {
        logic pin_en;
        logic [1:0] pin_func;
        acr_mode_t mode;
        logic duty_cycle_stabilizer;
        logic lsb_first;
    } acr_cfg_t;

    typedef enum logic [1:0]
    {
        ACR_ST_IDLE = 2'b00,
        ACR_ST_SRST = 2'b01,
        ACR_ST_COMMIT = 2'b10
    } acr_state_t;

endpackage

// ==== rtl/acr_reg_bank.sv ====
// What this block does
// - addresses and bits outside the map read zero and ignore writes, except port config bits 4:3, which read one
// - port config mirrors bit order, soft reset in both nibbles; reset 0x18
// - chip identifier at 0x01 is fixed, read only
// - speed-grade field at 0x02 read only, other bits zero
// - transfer bit at 0xFF copies staged registers to active copies
// - mode field: run, power-down, standby, digital reset; default 0x00
// - mode bit 7 enables mode pin; field picks its power function
// - clock bit 0 enables duty cycle stabilizer, reset 0x01
// - staged 0x08..0x09 writes act only after transfer commit
// - transfer bit clears itself after the update
// - port shifts msb first after reset until bit order changed
`timescale 1ns/100ps
`include "acr_regs.svh"

module acr_reg_bank #(
    parameter logic [7:0] CHIP_IDENTIFIER = 8'hA5, // arbitrary value
    parameter logic [2:0] SPEED_GRADE = 3'h7 // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire acr_pkg::acr_req_t req,
    output acr_pkg::acr_cfg_t cfg,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic dig_reset,
    output logic busy
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    acr_pkg::acr_state_t state_r, state_nxt;
    logic [7:0] port_r, port_nxt;
    logic [7:0] modes_r, modes_nxt;
    logic [7:0] clock_r, clock_nxt;
    logic [7:0] commit_r, commit_nxt;
    acr_pkg::acr_cfg_t cfg_r, cfg_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic dreset_r, dreset_nxt;
    logic busy_r, busy_nxt;

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    function automatic logic [7:0] rd_mux(input logic [7:0] a,
        input logic [7:0] p, input logic [7:0] m, input logic [7:0] c,
        input logic [7:0] t);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `ACR_ADDR_PORT_CFG: v = p;
            `ACR_ADDR_CHIP_IDENTIFIER: v = CHIP_IDENTIFIER;
            `ACR_ADDR_GRADE: v = {1'b0, SPEED_GRADE, 4'h0};
            `ACR_ADDR_MODES: v = m;
            `ACR_ADDR_CLOCK: v = c;
            `ACR_ADDR_COMMIT: v = t;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // mirror bit order and soft reset across nibbles
    function automatic logic [7:0] port_fold(input logic [7:0] w);
        logic lsb;
        logic srst;
        lsb = w[`ACR_BIT_LSB_HI] | w[`ACR_BIT_LSB_LO];
        srst = w[`ACR_BIT_RST_HI] | w[`ACR_BIT_RST_LO];
        return {1'b0, lsb, srst, 2'b11, srst, lsb, 1'b0};
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        port_nxt = port_r;
        modes_nxt = modes_r;
        clock_nxt = clock_r;
        commit_nxt = commit_r;
        cfg_nxt = cfg_r;
        case (state_r)
            acr_pkg::ACR_ST_IDLE:
            begin
                if (req.wr)
                begin
                    case (req.addr)
                        `ACR_ADDR_PORT_CFG:
                        begin
                            port_nxt = port_fold(req.wdata);
                            if (port_nxt[`ACR_BIT_RST_HI])
                            begin
                                state_nxt = acr_pkg::ACR_ST_SRST;
                            end
                        end
                        `ACR_ADDR_MODES:
                            modes_nxt = req.wdata & `ACR_MASK_MODES;
                        `ACR_ADDR_CLOCK:
                            clock_nxt = req.wdata & `ACR_MASK_CLOCK;
                        `ACR_ADDR_COMMIT:
                        begin
                            commit_nxt = {7'h00,
                                req.wdata[`ACR_BIT_COMMIT]};
                            if (req.wdata[`ACR_BIT_COMMIT])
                            begin
                                state_nxt = acr_pkg::ACR_ST_COMMIT;
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
            acr_pkg::ACR_ST_COMMIT:
            begin
                // all active copies update on the same edge
                cfg_nxt.pin_en = modes_r[`ACR_BIT_PIN_EN];
                cfg_nxt.pin_func =
                    modes_r[`ACR_BIT_FUNC_HI:`ACR_BIT_FUNC_LO];
                cfg_nxt.mode = acr_pkg::acr_mode_t'(
                    modes_r[`ACR_BIT_MODE_HI:`ACR_BIT_MODE_LO]);
                cfg_nxt.duty_cycle_stabilizer =
                    clock_r[`ACR_BIT_DCS];
                commit_nxt = `ACR_RST_COMMIT;
                state_nxt = acr_pkg::ACR_ST_IDLE;
            end
            acr_pkg::ACR_ST_SRST:
            begin
                // staged and active copies both go back to defaults
                port_nxt = `ACR_RST_PORT_CFG;
                modes_nxt = `ACR_RST_MODES;
                clock_nxt = `ACR_RST_CLOCK;
                commit_nxt = `ACR_RST_COMMIT;
                cfg_nxt.pin_en = 1'b0;
                cfg_nxt.pin_func = 2'b00;
                cfg_nxt.mode = acr_pkg::ACR_MODE_RUN;
                cfg_nxt.duty_cycle_stabilizer = 1'b1;
                state_nxt = acr_pkg::ACR_ST_IDLE;
            end
            default:
                state_nxt = acr_pkg::ACR_ST_IDLE;
        endcase
        cfg_nxt.lsb_first = port_nxt[`ACR_BIT_LSB_HI];
        dreset_nxt = (cfg_nxt.mode == acr_pkg::ACR_MODE_DRESET);
        // writes are refused while busy
        busy_nxt = (state_nxt != acr_pkg::ACR_ST_IDLE);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_r <= acr_pkg::ACR_ST_IDLE;
            port_r <= `ACR_RST_PORT_CFG;
            modes_r <= `ACR_RST_MODES;
            clock_r <= `ACR_RST_CLOCK;
            commit_r <= `ACR_RST_COMMIT;
            cfg_r <= '{pin_en: 1'b0, pin_func: 2'b00,
                mode: acr_pkg::ACR_MODE_RUN,
                duty_cycle_stabilizer: 1'b1, lsb_first: 1'b0};
            dreset_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            port_r <= port_nxt;
            modes_r <= modes_nxt;
            clock_r <= clock_nxt;
            commit_r <= commit_nxt;
            cfg_r <= cfg_nxt;
            dreset_r <= dreset_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // reads see the staged copies and the old value on a same-cycle write
    always_comb
    begin
        rvalid_nxt = req.rd;
        rdata_nxt = rdata_r;
        if (req.rd)
        begin
            rdata_nxt = rd_mux(req.addr, port_r, modes_r, clock_r,
                commit_r);
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign cfg = cfg_r;
    assign rdata = rdata_r;
    assign rvalid = rvalid_r;
    assign dig_reset = dreset_r;
    assign busy = busy_r;

endmodule

// ==== dv/acr_reg_bank_properties.sv ====
`timescale 1ns/100ps
module acr_reg_bank_properties #(
    parameter logic [7:0] CHIP_IDENTIFIER = 8'h00,
    parameter logic [2:0] SPEED_GRADE = 3'h0
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire acr_pkg::acr_req_t req,
    input wire acr_pkg::acr_cfg_t cfg,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic dig_reset,
    input wire logic busy
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    chk_id_read: assert property (req.rd && req.addr == 8'h01 |=>
        rvalid && rdata == CHIP_IDENTIFIER) else $error("bad id");
    chk_grade_read: assert property (req.rd && req.addr == 8'h02 |=>
        rdata == {1'b0, SPEED_GRADE, 4'h0}) else $error("bad grade");
    chk_port_form: assert property (req.rd && req.addr == 8'h00 |=>
        rdata[4:3] == 2'h3 && rdata[6:5] == {rdata[1], rdata[2]}
        && !rdata[7] && !rdata[0]) else $error("bad port form");
    chk_commit_pulse: assert property (req.wr && req.addr == 8'hFF
        && req.wdata[0] && !busy |=> busy ##1 !busy) else $error("bad commit");
    chk_shadow_hold: assert property (!busy |=> $stable(cfg[6:1]))
        else $error("cfg moved");
    chk_mode_reset: assert property (dig_reset ==
        (cfg.mode == acr_pkg::ACR_MODE_DRESET)) else $error("bad dig reset");
    chk_bit_order: assert property (req.wr && req.addr == 8'h00
        && !busy |=> cfg.lsb_first == |($past(req.wdata) & 8'h42))
        else $error("bad order");
    chk_soft_reset: assert property (req.wr && req.addr == 8'h00
        && |(req.wdata & 8'h24) && !busy |=> busy ##1 (!busy && cfg == 7'h02))
        else $error("bad soft reset");
    cover property (req.wr && req.addr == 8'hFF);
    cover property (dig_reset);
    cover property (busy ##1 cfg == 7'h02);
endmodule

// ==== dv/acr_host.sv ====
`timescale 1ns/100ps
module acr_host (
    input wire logic clk_sys,
    input wire logic [7:0] rdata,
    output acr_pkg::acr_req_t req
);
    initial req = '0;
    task automatic wr(input logic [7:0] a, d);
        req <= '{1'b1, 1'b0, a, d};
        @(negedge clk_sys);
        req <= '{1'b0, 1'b0, ~a, ~d};
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_sys);
        q = rdata;
        req <= '{1'b0, 1'b0, ~a, 8'hFF};
        @(negedge clk_sys);
    endtask
endmodule

// ==== dv/tb_acr_reg_bank.sv ====
`timescale 1ns/100ps
module tb_acr_reg_bank;
    localparam logic [7:0] ID = 8'h5C; // arbitrary value
    localparam logic [2:0] GR = 3'h3; // arbitrary value
    logic clk_sys, reset, rvalid, dig_reset, busy;
    acr_pkg::acr_req_t req;
    acr_pkg::acr_cfg_t cfg;
    logic [7:0] rdata;
    int mismatches = 0, tests_run = 0;
    logic [7:0] d [4] = '{8'hC1, 8'h22, 8'h03, 8'h00};
    logic [6:0] e = 7'h02;
    acr_reg_bank #(.CHIP_IDENTIFIER(ID), .SPEED_GRADE(GR)) DUT (.clk_sys(clk_sys),
        .reset(reset), .req(req), .cfg(cfg), .rdata(rdata),
        .rvalid(rvalid), .dig_reset(dig_reset), .busy(busy));
    acr_host host (.clk_sys(clk_sys), .rdata(rdata), .req(req));
    task automatic check(input string n, input logic [7:0] s, x);
        tests_run++;
        if (s !== x)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic r(input logic [7:0] a, x);
        logic [7:0] q;
        fork
            host.rd(a, q);
            begin
                @(negedge clk_sys);
                check("rvalid", {7'h00, rvalid}, 8'h01);
            end
        join
        check($sformatf("reg %h", a), q, x);
        check("rvalid idle", {7'h00, rvalid}, 8'h00);
    endtask
    task automatic w(input logic [7:0] a, v, input logic xb);
        fork
            host.wr(a, v);
            begin
                @(negedge clk_sys);
                check("busy", {7'h00, busy}, {7'h00, xb});
            end
        join
    endtask
    task automatic c(input logic [6:0] x);
        check("cfg", {1'b0, cfg}, {1'b0, x});
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial
    begin
        reset = 1'b1;
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        c(7'h02);
        r(8'h00, 8'h18);
        host.wr(8'h01, 8'hFF);
        host.wr(8'h02, 8'h70);
        host.wr(8'h01, 8'h3C);
        r(8'h01, ID);
        r(8'h02, {1'b0, GR, 4'h0});
        r(8'h05, 8'h00);
        foreach (d[i])
        begin
            w(8'h08, d[i], 1'h0);
            c(e);
            w(8'hFF, 8'h01, 1'h1);
            e = {d[i][7:5], d[i][1:0], 2'h2};
            c(e);
            check("dig_reset", {7'h00, dig_reset},
                {7'h00, d[i][1:0] == 2'h3});
            r(8'hFF, 8'h00);
        end
        w(8'h09, 8'h00, 1'h0);
        w(8'hFF, 8'h01, 1'h1);
        c(7'h00);
        host.wr(8'h00, 8'h40);
        r(8'h00, 8'h5A);
        c(7'h01);
        w(8'h00, 8'h04, 1'h1);
        c(7'h02);
        r(8'h09, 8'h01);
        report_and_stop();
    end
endmodule
bind acr_reg_bank acr_reg_bank_properties #(.CHIP_IDENTIFIER(CHIP_IDENTIFIER),
    .SPEED_GRADE(SPEED_GRADE)) chk (.clk_sys(clk_sys), .reset(reset),
    .req(req), .cfg(cfg), .rdata(rdata), .rvalid(rvalid),
    .dig_reset(dig_reset), .busy(busy));
